// ===== rtl/lsc_exec.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: Exclusive OR puts acc P..35 xor storage into acc; storage kept; S, Q cleared.
// RULE2: Exclusive OR formed as twice the OR minus the arithmetic sum.
// RULE3: Skip tests skip at most one; the two compares skip zero, one or two.
// RULE4: Skip-one address is program counter plus one, unless not a skip operation.
// RULE5: Skip-two address is previous address under overlap, else address register plus one.
// RULE6: A met skip sets the general skip trigger plus the one or two trigger.
// RULE7: Storage-zero test skips one when storage bits 1..35 are all zero.
// RULE8: Storage-non-zero test skips one when any storage bit 1..35 is one.
// RULE9: Low-bit test skips one when accumulator bit 35 is one.
// RULE10: P-position test skips one when accumulator position P is one.
// RULE11: Divide-fault test clears a set trigger without skip, else skips one.
// RULE12: Switch test addresses 161..166 select switches 1..6; skip when on.
// RULE13: Test decode uses the effective address after index modification.
// RULE14: Signed compare: greater skips none, equal one, less two.
// RULE15: Signed compare loads storage register then adds it to complemented accumulator.
// RULE16: Signed compare skip two on minus acc with plus storage or nonzero less; equal skips one.
// RULE17: Logical compare of acc Q..35 with storage S..35, no sign treatment.
// RULE18: Logical compare loads storage register then adds it to complemented accumulator.
// RULE19: Convert uses six-bit groups; first group plus address locates first table word.
// RULE20: Replacement convert shifts six places and inserts table bits S..5.
// RULE21: Convert makes exactly count references, never more than six.
// RULE22: Convert ignores tag bits 18, 19; bit 20 stores last table start to index A.
// RULE23: Accumulator convert decodes from plus 0114; I, L and up to six E cycles.
// RULE24: One L cycle loads count and first location; one E cycle per reference.
// RULE25: Each reference shifts acc right six and puts table S..5 into P..5.
// RULE26: The sign preceding the opcode is part of the decode.
// RULE27: With no skip met all skip triggers stay off; next address is sequential.
module lsc_exec (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // APB slave
   input wire logic [lsc_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core storage read port
   output logic stgReq,
   output logic [lsc_pkg::ADDR_W-1:0] stgAddr,
   input wire logic stgAck,
   input wire logic [lsc_pkg::WORD_W-1:0] stgData,
   // Console
   input wire logic [lsc_pkg::NSW-1:0] senseSwitch,
   output logic busy
);
   import lsc_pkg::*;

   lsc_state_t state_reg;
   logic [11:0] opcode_reg;
   logic minus_reg;
   logic [2:0] tag_reg;
   logic [5:0] count_reg;
   logic [ADDR_W-1:0] iaddr_reg, eaddr_reg, pc_reg, prev_reg, ar_reg, skipOneAddr_reg, next_reg, xra_reg;
   logic [ACC_W-1:0] acc_reg;
   logic [WORD_W-1:0] sr_reg;
   logic [1:0] skipN_reg;
   logic [2:0] refs_reg;
   logic skip_reg, skipOne_reg, skipTwo_reg, divCheck_reg, overlap_reg;
   logic [NSW-1:0] swMeta_reg, swSync_reg, swAge_reg, swStable_reg;

   logic wrAcc, rdSetup, mapped, startPulse, idle;
   logic isXor, isZet, isNzt, isAtest, isLbt, isPbt, isDct, isSwt, isCas, isLas, isCvr, isSkipOp;
   logic [36:0] orTwice, addSum, xorVal;
   logic [36:0] cmpA;
   logic [37:0] cmpSum;
   logic qCarry, sumZero;
   logic [1:0] cmpSkip;
   logic [2:0] swIdx;
   logic [31:0] rdData;

   assign idle = (state_reg == ST_IDLE);
   assign busy = !idle;
   assign wrAcc = psel && penable && pwrite;
   assign rdSetup = psel && !penable;
   assign startPulse = wrAcc && (paddr == R_CTRL) && pwdata[CTRL_START_BIT] && idle;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign stgReq = (state_reg == ST_MEM) || (state_reg == ST_CVE);
   assign stgAddr = ar_reg;

   // Sense switches come from the console: three flops, accept when the last two agree
   for (genvar i = 0; i < NSW; i++) begin : g_sw
      always_ff @(posedge clock) begin
         if (srst) begin
            swMeta_reg[i] <= 1'b0;
            swSync_reg[i] <= 1'b0;
            swAge_reg[i] <= 1'b0;
            swStable_reg[i] <= 1'b0;
         end else begin
            swMeta_reg[i] <= senseSwitch[i];
            swSync_reg[i] <= swMeta_reg[i];
            swAge_reg[i] <= swSync_reg[i];
            if (swSync_reg[i] == swAge_reg[i]) begin
               swStable_reg[i] <= swAge_reg[i];
            end
         end
      end
   end

   // RULE26: signed decode
   // RULE13: effective address decode
   always_comb begin
      isXor = !minus_reg && opcode_reg == OP_XOR;
      isZet = !minus_reg && opcode_reg == OP_ZTEST;
      isNzt = minus_reg && opcode_reg == OP_ZTEST;
      isAtest = opcode_reg == OP_ATEST;
      isLbt = isAtest && !minus_reg && eaddr_reg == EA_LOW;
      isPbt = isAtest && minus_reg && eaddr_reg == EA_LOW;
      isDct = isAtest && !minus_reg && eaddr_reg == EA_DIV;
      isSwt = isAtest && !minus_reg && eaddr_reg >= EA_SW_FIRST && eaddr_reg <= EA_SW_LAST;
      isCas = !minus_reg && opcode_reg == OP_CMP;
      isLas = minus_reg && opcode_reg == OP_CMP;
      // RULE23: convert decode
      isCvr = !minus_reg && opcode_reg == OP_CVR;
      isSkipOp = isZet || isNzt || isLbt || isPbt || isDct || isSwt || isCas || isLas;
   end

   // RULE2: adder-based exclusive OR, result never exceeds 36 bits
   assign orTwice = {acc_reg[ACC_P:0] | sr_reg, 1'b0};
   assign addSum = {1'b0, acc_reg[ACC_P:0]} + {1'b0, sr_reg};
   assign xorVal = orTwice - addSum;

   // RULE15: storage 1..35 against complemented acc Q..35
   // RULE17: unsigned, no sign treatment
   // RULE18: logical compare widens storage to S..35
   assign cmpA = isLas ? {1'b0, sr_reg} : {2'b00, sr_reg[STG_S-1:0]};
   assign cmpSum = {1'b0, cmpA} + {1'b0, ~acc_reg[ACC_Q:0]} + 38'h0000000001;
   assign qCarry = cmpSum[37];
   assign sumZero = (cmpSum[36:0] == 37'h0000000000);

   // Q carry means the storage magnitude is not below the accumulator magnitude
   always_comb begin
      cmpSkip = qCarry ? (sumZero ? 2'h1 : 2'h2) : 2'h0;
      if (isCas) begin
         // RULE16: sign cases
         if (!sr_reg[STG_S] && acc_reg[ACC_S]) begin
            cmpSkip = 2'h2;
         end else if (sr_reg[STG_S] && !acc_reg[ACC_S]) begin
            cmpSkip = 2'h0;
         end else if (sr_reg[STG_S]) begin
            cmpSkip = sumZero ? 2'h1 : (qCarry ? 2'h0 : 2'h2);
         end
      end
   end

   assign swIdx = 3'(eaddr_reg - EA_SW_FIRST);

   // Sequencer: I decode, E4 storage load, E5/L evaluate, E/L3 and E/L4 address forming
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (startPulse) begin
                  state_reg <= ST_DEC;
               end
            end
            ST_DEC: begin
               if (isCvr) begin
                  state_reg <= ST_CVL;
               end else if (isXor || isZet || isNzt || isCas || isLas) begin
                  state_reg <= ST_MEM;
               end else if (isSkipOp) begin
                  state_reg <= ST_EVAL;
               end else begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_MEM: begin
               if (stgAck) begin
                  state_reg <= ST_EVAL;
               end
            end
            ST_EVAL: state_reg <= isSkipOp ? ST_ADR1 : ST_IDLE;
            ST_ADR1: state_reg <= ST_ADR2;
            ST_ADR2: state_reg <= ST_IDLE;
            // RULE24: one L cycle, then one E cycle per reference
            ST_CVL: state_reg <= (count_reg == 6'h00) ? ST_IDLE : ST_CVE;
            ST_CVE: begin
               // RULE21: stop after the counted references
               if (stgAck && refs_reg == 3'h1) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Instruction fields and addresses, writable only while idle; overlap bit writable any time
   always_ff @(posedge clock) begin
      if (srst) begin
         opcode_reg <= 12'h000;
         minus_reg <= 1'b0;
         tag_reg <= 3'h0;
         count_reg <= 6'h00;
         iaddr_reg <= 15'h0000;
         eaddr_reg <= 15'h0000;
         pc_reg <= 15'h0000;
         prev_reg <= 15'h0000;
         overlap_reg <= 1'b0;
      end else if (wrAcc) begin
         if (paddr == R_CTRL) begin
            overlap_reg <= pwdata[CTRL_OVL_BIT];
         end
         if (idle) begin
            case (paddr)
               R_INSTR: begin
                  opcode_reg <= pwdata[IN_OP_LO+:12];
                  minus_reg <= pwdata[IN_SIGN_BIT];
                  tag_reg <= pwdata[IN_TAG_LO+:3];
                  count_reg <= pwdata[IN_CNT_LO+:6];
               end
               R_IADDR: iaddr_reg <= pwdata[ADDR_W-1:0];
               R_EADDR: eaddr_reg <= pwdata[ADDR_W-1:0];
               R_PC: pc_reg <= pwdata[ADDR_W-1:0];
               R_PREV: prev_reg <= pwdata[ADDR_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Accumulator, storage register and convert count
   always_ff @(posedge clock) begin
      if (srst) begin
         acc_reg <= '0;
         sr_reg <= '0;
         refs_reg <= 3'h0;
         xra_reg <= 15'h0000;
      end else begin
         if (idle && wrAcc && paddr == R_ACC_LO) begin
            acc_reg[31:0] <= pwdata;
         end
         if (idle && wrAcc && paddr == R_ACC_HI) begin
            acc_reg[ACC_W-1:32] <= pwdata[ACC_W-33:0];
         end
         if (state_reg == ST_MEM && stgAck) begin
            sr_reg <= stgData;
         end
         if (state_reg == ST_EVAL && isXor) begin
            // RULE1: P..35 take the exclusive OR, S and Q cleared
            acc_reg <= {2'b00, xorVal[ACC_P:0]};
         end
         if (state_reg == ST_CVL) begin
            // RULE21: never more than six references
            refs_reg <= (count_reg > {3'h0, MAX_REFS}) ? MAX_REFS : count_reg[2:0];
         end
         if (state_reg == ST_CVE && stgAck) begin
            sr_reg <= stgData;
            // RULE20: shift six, vacated end takes table S..5
            // RULE25: right shift into P..5
            acc_reg[ACC_P:0] <= {stgData[STG_S-:GRP_W], acc_reg[ACC_P:GRP_W]};
            refs_reg <= refs_reg - 3'h1;
            // RULE22: only tag position 20 matters
            if (refs_reg == 3'h1 && tag_reg[IN_TAG20_BIT-IN_TAG_LO]) begin
               xra_reg <= stgData[ADDR_W-1:0];
            end
         end
      end
   end

   // Address register: operand address, table address and skip addresses
   always_ff @(posedge clock) begin
      if (srst) begin
         ar_reg <= 15'h0000;
         skipOneAddr_reg <= 15'h0000;
         next_reg <= 15'h0000;
      end else begin
         case (state_reg)
            ST_DEC: begin
               ar_reg <= eaddr_reg;
               next_reg <= pc_reg;
            end
            // RULE19: first group plus instruction address
            ST_CVL: ar_reg <= iaddr_reg + {9'h000, acc_reg[GRP_W-1:0]};
            ST_CVE: begin
               if (stgAck) begin
                  // RULE19: next table start plus the group now aligned
                  ar_reg <= stgData[ADDR_W-1:0] + {9'h000, acc_reg[2*GRP_W-1:GRP_W]};
               end
            end
            ST_ADR1: begin
               // RULE4: program counter through the adder with a carry
               ar_reg <= pc_reg + 15'h0001;
               skipOneAddr_reg <= pc_reg + 15'h0001;
            end
            ST_ADR2: begin
               // RULE5: overlap reuses the earlier address
               ar_reg <= overlap_reg ? prev_reg : ar_reg + 15'h0001;
               // RULE27: no skip keeps the sequential address
               if (skipN_reg == 2'h1) begin
                  next_reg <= skipOneAddr_reg;
               end else if (skipN_reg == 2'h2) begin
                  next_reg <= overlap_reg ? prev_reg : ar_reg + 15'h0001;
               end
            end
            default: ;
         endcase
      end
   end

   // Skip condition and triggers
   always_ff @(posedge clock) begin
      if (srst) begin
         skipN_reg <= 2'h0;
         skip_reg <= 1'b0;
         skipOne_reg <= 1'b0;
         skipTwo_reg <= 1'b0;
      end else begin
         if (startPulse) begin
            skipN_reg <= 2'h0;
            skip_reg <= 1'b0;
            skipOne_reg <= 1'b0;
            skipTwo_reg <= 1'b0;
         end
         if (state_reg == ST_EVAL) begin
            // RULE3: only the compares can reach two
            if (isCas || isLas) begin
               // RULE14: signed and logical compare outcome
               skipN_reg <= cmpSkip;
            end else if (isZet) begin
               // RULE7: storage 1..35 zero
               skipN_reg <= {1'b0, sr_reg[STG_S-1:0] == 35'h000000000};
            end else if (isNzt) begin
               // RULE8: storage 1..35 nonzero
               skipN_reg <= {1'b0, sr_reg[STG_S-1:0] != 35'h000000000};
            end else if (isLbt) begin
               // RULE9: low-order bit
               skipN_reg <= {1'b0, acc_reg[0]};
            end else if (isPbt) begin
               // RULE10: P position
               skipN_reg <= {1'b0, acc_reg[ACC_P]};
            end else if (isDct) begin
               // RULE11: skip only when no divide fault
               skipN_reg <= {1'b0, !divCheck_reg};
            end else if (isSwt) begin
               // RULE12: selected switch
               skipN_reg <= {1'b0, swStable_reg[swIdx]};
            end else begin
               skipN_reg <= 2'h0;
            end
         end
         if (state_reg == ST_ADR2 && skipN_reg != 2'h0) begin
            // RULE6: general trigger plus count trigger
            skip_reg <= 1'b1;
            skipOne_reg <= (skipN_reg == 2'h1);
            skipTwo_reg <= (skipN_reg == 2'h2);
         end
      end
   end

   // Divide check trigger: software set wins over the test's clear
   always_ff @(posedge clock) begin
      if (srst) begin
         divCheck_reg <= 1'b0;
      end else if (wrAcc && paddr == R_CTRL && pwdata[CTRL_DIV_BIT]) begin
         divCheck_reg <= 1'b1;
      end else if (state_reg == ST_EVAL && isDct) begin
         // RULE11: trigger turned off
         divCheck_reg <= 1'b0;
      end
   end

   // Register read, sampled in the setup phase so prdata is a flop in the access phase
   always_comb begin
      rdData = 32'h00000000;
      mapped = 1'b1;
      case (paddr)
         R_CTRL: begin
            rdData[CTRL_DIV_BIT] = divCheck_reg;
            rdData[CTRL_OVL_BIT] = overlap_reg;
         end
         R_STATUS: begin
            rdData[STAT_BUSY_BIT] = busy;
            rdData[STAT_SKIP_BIT] = skip_reg;
            rdData[STAT_ONE_BIT] = skipOne_reg;
            rdData[STAT_TWO_BIT] = skipTwo_reg;
            rdData[STAT_DIV_BIT] = divCheck_reg;
            rdData[STAT_SW_LO+:NSW] = swStable_reg;
         end
         R_INSTR: begin
            rdData[IN_OP_LO+:12] = opcode_reg;
            rdData[IN_SIGN_BIT] = minus_reg;
            rdData[IN_TAG_LO+:3] = tag_reg;
            rdData[IN_CNT_LO+:6] = count_reg;
         end
         R_IADDR: rdData[ADDR_W-1:0] = iaddr_reg;
         R_EADDR: rdData[ADDR_W-1:0] = eaddr_reg;
         R_PC: rdData[ADDR_W-1:0] = pc_reg;
         R_PREV: rdData[ADDR_W-1:0] = prev_reg;
         R_ACC_LO: rdData = acc_reg[31:0];
         R_ACC_HI: rdData[ACC_W-33:0] = acc_reg[ACC_W-1:32];
         R_SR_LO: rdData = sr_reg[31:0];
         R_SR_HI: rdData[WORD_W-33:0] = sr_reg[WORD_W-1:32];
         R_AR: rdData[ADDR_W-1:0] = ar_reg;
         R_NEXT: rdData[ADDR_W-1:0] = next_reg;
         R_XRA: rdData[ADDR_W-1:0] = xra_reg;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         prdata <= 32'h00000000;
      end else if (rdSetup) begin
         prdata <= rdData;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   a_xor_result: assert property (state_reg == ST_EVAL && isXor |=> // RULE1
      acc_reg == {2'b00, $past(acc_reg[ACC_P:0]) ^ $past(sr_reg)}) else $error("xor result wrong");
   a_skip_bound: assert property (state_reg == ST_ADR2 && !(isCas || isLas) |-> // RULE3
      skipN_reg <= 2'h1) else $error("test skipped more than one");
   a_skip_one_addr: assert property (state_reg == ST_ADR1 |=> // RULE4
      skipOneAddr_reg == $past(pc_reg) + 15'h0001) else $error("skip one address wrong");
   a_skip_two_addr: assert property (state_reg == ST_ADR2 && !overlap_reg |=> // RULE5
      ar_reg == $past(ar_reg) + 15'h0001) else $error("skip two address wrong");
   a_trig_pair: assert property (state_reg == ST_ADR2 && skipN_reg != 2'h0 |=> // RULE6
      skip_reg && (skipOne_reg != skipTwo_reg)) else $error("skip triggers inconsistent");
   a_zero_test: assert property (state_reg == ST_EVAL && isZet |=> // RULE7
      skipN_reg == {1'b0, $past(sr_reg[STG_S-1:0]) == 35'h000000000}) else $error("zero test wrong");
   a_low_bit: assert property (state_reg == ST_EVAL && isLbt |=> // RULE9
      skipN_reg[0] == $past(acc_reg[0])) else $error("low bit test wrong");
   a_div_clear: assert property (state_reg == ST_EVAL && isDct && divCheck_reg |=> // RULE11
      skipN_reg == 2'h0 ##2 !skip_reg) else $error("divide test wrong");
   a_las_order: assert property (state_reg == ST_EVAL && isLas |=> // RULE17
      skipN_reg == (($past(acc_reg[ACC_Q:0]) < {1'b0, $past(sr_reg)}) ? 2'h2 :
      (($past(acc_reg[ACC_Q:0]) == {1'b0, $past(sr_reg)}) ? 2'h1 : 2'h0))) else $error("logical compare wrong");
   a_refs_limit: assert property (refs_reg <= MAX_REFS) else $error("too many references"); // RULE21
   a_cvr_shift: assert property (state_reg == ST_CVE && stgAck |=> // RULE25
      acc_reg[ACC_P:0] == {$past(stgData[STG_S-:GRP_W]), $past(acc_reg[ACC_P:GRP_W])}) else $error("shift wrong");

   c_skip_two: cover property (state_reg == ST_ADR2 && skipN_reg == 2'h2);
   c_convert_done: cover property (state_reg == ST_CVE && stgAck && refs_reg == 3'h1);
   c_div_cleared: cover property (state_reg == ST_EVAL && isDct && divCheck_reg);
   c_overlap_skip: cover property (state_reg == ST_ADR2 && overlap_reg && skipN_reg == 2'h2);
endmodule

// ===== rtl/lsc_pkg.sv
package lsc_pkg;
   // Word geometry: accumulator index 37 = S, 36 = Q, 35 = P, 34..0 = positions 1..35
   localparam int ADDR_W = 15;
   localparam int WORD_W = 36;
   localparam int ACC_W = 38;
   localparam int ACC_S = 37;
   localparam int ACC_Q = 36;
   localparam int ACC_P = 35;
   localparam int STG_S = 35;
   localparam int GRP_W = 6;
   localparam int APB_AW = 8;
   localparam int NSW = 6;

   // Operation codes (octal 0322, 0520, 0760, 0340, 0114); sign kept separately
   localparam logic [11:0] OP_XOR = 12'h0D2;
   localparam logic [11:0] OP_ZTEST = 12'h150;
   localparam logic [11:0] OP_ATEST = 12'h1F0;
   localparam logic [11:0] OP_CMP = 12'h0E0;
   localparam logic [11:0] OP_CVR = 12'h04C;

   // Effective addresses selecting the accumulator-side tests
   localparam logic [14:0] EA_LOW = 15'h0001;
   localparam logic [14:0] EA_DIV = 15'h000A;
   localparam logic [14:0] EA_SW_FIRST = 15'h0071;
   localparam logic [14:0] EA_SW_LAST = 15'h0076;

   localparam logic [2:0] MAX_REFS = 3'h6;

   // Register byte offsets
   localparam logic [7:0] R_CTRL = 8'h00;
   localparam logic [7:0] R_STATUS = 8'h04;
   localparam logic [7:0] R_INSTR = 8'h08;
   localparam logic [7:0] R_IADDR = 8'h0C;
   localparam logic [7:0] R_EADDR = 8'h10;
   localparam logic [7:0] R_PC = 8'h14;
   localparam logic [7:0] R_PREV = 8'h18;
   localparam logic [7:0] R_ACC_LO = 8'h1C;
   localparam logic [7:0] R_ACC_HI = 8'h20;
   localparam logic [7:0] R_SR_LO = 8'h24;
   localparam logic [7:0] R_SR_HI = 8'h28;
   localparam logic [7:0] R_AR = 8'h2C;
   localparam logic [7:0] R_NEXT = 8'h30;
   localparam logic [7:0] R_XRA = 8'h34;

   // Field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_DIV_BIT = 1;
   localparam int CTRL_OVL_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_SKIP_BIT = 1;
   localparam int STAT_ONE_BIT = 2;
   localparam int STAT_TWO_BIT = 3;
   localparam int STAT_DIV_BIT = 4;
   localparam int STAT_SW_LO = 5;
   localparam int IN_OP_LO = 0;
   localparam int IN_SIGN_BIT = 12;
   localparam int IN_TAG_LO = 13;
   localparam int IN_TAG20_BIT = 15;
   localparam int IN_CNT_LO = 16;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_DEC = 8'h02,
      ST_MEM = 8'h04,
      ST_EVAL = 8'h08,
      ST_ADR1 = 8'h10,
      ST_ADR2 = 8'h20,
      ST_CVL = 8'h40,
      ST_CVE = 8'h80
   } lsc_state_t;
endpackage

// ===== verif/lsc_exec_test.sv
`timescale 1ns/100ps
module lsc_exec_test;
   import lsc_pkg::*;
   typedef struct packed {logic [12:0] op; logic [7:0] ea; logic [37:0] acc; logic [35:0] wd; logic [1:0] sk;} lsc_row_t;
   localparam logic [12:0] ZT = {1'b0, OP_ZTEST}, NZ = {1'b1, OP_ZTEST}, AT = {1'b0, OP_ATEST}, PT = {1'b1, OP_ATEST};
   localparam logic [12:0] CS = {1'b0, OP_CMP}, LS = {1'b1, OP_CMP}, XR = {1'b0, OP_XOR};
   localparam logic [14:0] PCB = 15'h0100;
   logic clock, srst, psel, penable, pwrite, pready, pslverr, stgReq, stgAck, busy, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] stgAddr;
   logic [35:0] stgData, cv;
   logic [5:0] senseSwitch;
   logic [3:0] stgWait;
   logic [2:0] ctrlBits;
   logic [37:0] accGot, nextGot, statGot;
   int nErrors, testsRun, acks0, acks = 0;
   lsc_row_t r;
   lsc_row_t tv [19] = '{'{ZT, 8'h20, 38'h0, 36'h800000000, 2'h1}, '{ZT, 8'h21, 38'h0, 36'h1, 2'h0},
      '{NZ, 8'h22, 38'h0, 36'h400000000, 2'h1}, '{NZ, 8'h23, 38'h0, 36'h800000000, 2'h0},
      '{AT, 8'h01, 38'h1, 36'h0, 2'h1}, '{AT, 8'h01, 38'h0800000000, 36'h0, 2'h0},
      '{PT, 8'h01, 38'h0800000000, 36'h0, 2'h1}, '{PT, 8'h01, 38'h1, 36'h0, 2'h0},
      '{AT, 8'h0A, 38'h0, 36'h0, 2'h1}, '{AT, 8'h71, 38'h0, 36'h0, 2'h1}, '{AT, 8'h76, 38'h0, 36'h0, 2'h0},
      '{CS, 8'h24, 38'h5, 36'h5, 2'h1}, '{CS, 8'h25, 38'h3, 36'h5, 2'h2},
      '{CS, 8'h27, 38'h2000000003, 36'h1, 2'h2}, '{CS, 8'h28, 38'h1, 36'h800000003, 2'h0},
      '{CS, 8'h29, 38'h2000000003, 36'h800000005, 2'h0}, '{LS, 8'h2A, 38'h5, 36'h800000000, 2'h2},
      '{LS, 8'h2B, 38'h1000000000, 36'h800000005, 2'h0}, '{XR, 8'h2D, 38'h3F0000FFFF, 36'hF0F0F0F0F, 2'h3}};
   lsc_exec lsc_exec_inst (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stgReq(stgReq),
      .stgAddr(stgAddr), .stgAck(stgAck), .stgData(stgData), .senseSwitch(senseSwitch), .busy(busy));
   lsc_stg_model lsc_stg_model_inst (.clock(clock), .stgReq(stgReq), .stgAddr(stgAddr), .waitCycles(stgWait),
      .stgAck(stgAck), .stgData(stgData));
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [37:0] e, input logic [37:0] g);
      testsRun++;
      if (g !== e) begin
         nErrors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic runOp(input logic [21:0] ins, input logic [14:0] ia, input logic [14:0] ea, input logic [37:0] acc);
      apb(1'b1, R_INSTR, {10'h0, ins});
      apb(1'b1, R_IADDR, {17'h0, ia});
      apb(1'b1, R_EADDR, {17'h0, ea});
      apb(1'b1, R_PC, {17'h0, PCB});
      apb(1'b1, R_ACC_LO, acc[31:0]);
      apb(1'b1, R_ACC_HI, {26'h0, acc[37:32]});
      apb(1'b1, R_CTRL, {29'h0, ctrlBits} | 32'h1);
      @(negedge clock);
      while (busy !== 1'b0) @(negedge clock);
      apb(1'b0, R_ACC_HI, 32'h0);
      accGot[37:32] = rd[5:0];
      apb(1'b0, R_ACC_LO, 32'h0);
      accGot[31:0] = rd;
      apb(1'b0, R_NEXT, 32'h0);
      nextGot = 38'(rd);
      apb(1'b0, R_STATUS, 32'h0);
      statGot = 38'(rd);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) if (stgAck === 1'b1) acks++;
   // Switches 1 and 4 on, the rest off
   initial begin
      {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
      {senseSwitch, stgWait, ctrlBits} = {6'h09, 4'h0, 3'h0};
      {nErrors, testsRun} = {32'h0, 32'h0};
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      apb(1'b0, R_STATUS, 32'h0);
      chk("status", 38'h0, 38'(rd));
      apb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 38'h1, {37'(rd), err});
      $display("reset test done");
      foreach (tv[i]) begin
         r = tv[i];
         stgWait <= 4'(i % 5);
         lsc_stg_model_inst.mem[r.ea[5:0]] = r.wd;
         runOp({9'h0, r.op}, {7'h0, r.ea ^ 8'h01}, {7'h0, r.ea}, r.acc);
         chk("acc", (r.op == XR) ? {2'b00, r.acc[35:0] ^ r.wd} : r.acc, accGot);
         if (r.sk != 2'h3) begin
            chk("next", 38'(PCB + 15'(r.sk)), nextGot);
            chk("trig", 38'({r.sk == 2'h2, r.sk == 2'h1, r.sk != 2'h0, 1'b0}), statGot & 38'hF);
         end
         $display("row %0d done", i);
      end
      apb(1'b1, R_CTRL, 32'h2);
      runOp({9'h0, AT}, 15'h000B, 15'h000A, 38'h0);
      chk("divNext", 38'(PCB), nextGot);
      chk("divTrig", 38'h0, statGot & 38'h1E);
      $display("divide check test done");
      apb(1'b1, R_PREV, 32'h55);
      ctrlBits = 3'h4;
      lsc_stg_model_inst.mem[6'h25] = 36'h5;
      runOp({9'h0, CS}, 15'h0024, 15'h0025, 38'h3);
      chk("ovlNext", 38'h55, nextGot);
      ctrlBits = 3'h0;
      $display("overlap test done");
      lsc_stg_model_inst.mem[6'h13] = {6'h05, 15'h0, 15'h0020};
      lsc_stg_model_inst.mem[6'h22] = {6'h2A, 15'h0, 15'h0030};
      cv = 36'h83;
      cv = {6'h05, cv[35:6]};
      cv = {6'h2A, cv[35:6]};
      acks0 = acks;
      runOp({6'h02, 3'h7, 1'b0, OP_CVR}, 15'h0010, 15'h0010, 38'h83);
      chk("cvtAcc", 38'(cv), 38'(accGot[35:0]));
      chk("cvtRefs", 38'h2, 38'(acks - acks0));
      apb(1'b0, R_XRA, 32'h0);
      chk("indexA", 38'h30, 38'(rd));
      $display("convert test done");
      acks0 = acks;
      runOp({10'h0, OP_CVR}, 15'h0010, 15'h0010, 38'h83);
      chk("cvtNone", 38'h83, accGot);
      chk("cvtNoRef", 38'h0, 38'(acks - acks0));
      $display("zero count convert test done");
      apb(1'b1, R_INSTR, {19'h0, CS});
      apb(1'b1, R_CTRL, 32'h1);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      apb(1'b0, R_STATUS, 32'h0);
      chk("rstStat", 38'h0, 38'(rd & 32'hF));
      apb(1'b0, R_NEXT, 32'h0);
      chk("rstNext", 38'h0, 38'(rd));
      $display("mid-run reset test done");
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clock);
      nErrors++;
      complete_run();
   end
endmodule

// ===== verif/lsc_stg_model.sv
`timescale 1ns/100ps
module lsc_stg_model (
   // Clock
   input wire logic clock,
   // Read port
   input wire logic stgReq,
   input wire logic [lsc_pkg::ADDR_W-1:0] stgAddr,
   input wire logic [3:0] waitCycles,
   output logic stgAck,
   output logic [lsc_pkg::WORD_W-1:0] stgData
);
   logic [35:0] mem [0:63];
   logic [3:0] cnt;
   initial begin
      stgAck = 1'b0;
      stgData = 36'h0;
      cnt = 4'h0;
   end
   always @(posedge clock) begin
      stgAck <= 1'b0;
      // Bus inverts its word every cycle outside the answer cycle
      stgData <= ~stgData;
      if (stgReq && !stgAck) begin
         cnt <= cnt + 4'h1;
         if (cnt >= waitCycles) begin
            stgAck <= 1'b1;
            stgData <= mem[stgAddr[5:0]];
            cnt <= 4'h0;
         end
      end
   end
endmodule
